// file: tb/fuart_serial_peer.sv
`timescale 1ns/100ps
module fuart_serial_peer
(
  input  wire logic clk_i,
  input  wire logic line_in_i,
  output logic      line_out_o
);
  int         bit_clks = 32;
  int         frame_err = 0;
  logic [7:0] got[$];
  logic [7:0] sh;

  // Line idles at mark
  initial line_out_o = 1'b1;

  // Send start, eight data bits LSB first, stop
  task automatic send_byte(input logic [7:0] b, input logic stop_ok);
    logic [9:0] f;
    f = {stop_ok, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk_i) line_out_o <= f[i];
      repeat (bit_clks - 1) @(posedge clk_i);
    end
    @(posedge clk_i) line_out_o <= 1'b1;
    repeat (bit_clks) @(posedge clk_i);
  endtask

  // Receive frames at mid bit
  always
  begin
    @(negedge line_in_i);
    repeat (bit_clks / 2) @(posedge clk_i);
    if (line_in_i === 1'b0)
    begin
      for (int i = 0; i < 8; i++)
      begin
        repeat (bit_clks) @(posedge clk_i);
        sh[i] = line_in_i;
      end
      repeat (bit_clks) @(posedge clk_i);
      if (line_in_i !== 1'b1)
        frame_err++;
      got.push_back(sh);
    end
  end
endmodule

// file: tb/testbench.sv
`timescale 1ns/100ps
`define CHECK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin failures++; \
  $display("FAIL %s expected %h seen %h", nm, ex, gt); end end
module testbench;
  import fuart_pkg::*;
  localparam logic [11:0] A_DATA = {FUART_IDX_DATA, 2'b00};
  localparam logic [11:0] A_STAT = {FUART_IDX_STATUS, 2'b00};
  localparam logic [11:0] A_DIV  = {FUART_IDX_DIVISOR, 2'b00};
  localparam logic [11:0] A_TRIG = {FUART_IDX_TRIGGER, 2'b00};
  localparam logic [11:0] A_IST  = {FUART_IDX_INT_ST, 2'b00};
  localparam logic [11:0] A_IMSK = {FUART_IDX_INT_MSK, 2'b00};
  localparam logic [11:0] A_BAD  = 12'h400;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        tx, tx_oe, irq, rx;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [1:0]  r;
  int          failures = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #20 clk = ~clk;

  fuart_top i_fuart_top (
    .SYS_CLK_I(clk), .SYS_RST_I(rst),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .UART_RX_I(rx), .UART_TX_O(tx), .UART_TX_OE_O(tx_oe), .IRQ_O(irq)
  );

  fuart_serial_peer i_fuart_serial_peer (.clk_i(clk), .line_in_i(tx), .line_out_o(rx));

  // Write cycle; handshakes judged on settled values before the edge
  task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ha, hw, hb, da, dw, db;
    da = 0; dw = 0; db = 0;
    @(posedge clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= v; wvalid <= 1'b1; bready <= 1'b1;
    while (!db)
    begin
      @(negedge clk);
      ha = awvalid & awready; hw = wvalid & wready; hb = bvalid & bready; rs = bresp;
      @(posedge clk);
      if (ha) begin awvalid <= 1'b0; da = 1; end
      if (hw) begin wvalid <= 1'b0; dw = 1; end
      if (hb) begin bready <= 1'b0; db = 1; end
    end
  endtask

  // Read cycle
  task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ha, hr, dr;
    dr = 0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!dr)
    begin
      @(negedge clk);
      ha = arvalid & arready; hr = rvalid & rready; v = rdata; rs = rresp;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
      if (hr) begin rready <= 1'b0; dr = 1; end
    end
  endtask

  // Status polling before data access
  task automatic poll(input int pos, input logic val);
    int n;
    for (n = 0; n < 3000; n++)
    begin
      axi_read(A_STAT, d, r);
      if (d[pos] === val) break;
    end
    `CHECK("poll status", val, d[pos])
  endtask

  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      summarize();
    end
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axi_read(A_STAT, d, r); `CHECK("status reset", 32'h0, d)
    axi_read(A_TRIG, d, r); `CHECK("trigger reset", 32'h0, d)
    axi_read(A_IMSK, d, r); `CHECK("mask reset", 32'h0, d)
    axi_read(A_IST, d, r); `CHECK("int status reset", 32'h0, d)
    `CHECK("tx idle", 1'b1, tx)
    `CHECK("pins off", 1'b0, tx_oe)
    `CHECK("irq reset", 1'b0, irq)
    end_test("reset");
    axi_read(A_BAD, d, r); `CHECK("bad read resp", FUART_RESP_SLVERR, r)
    `CHECK("bad read data", 32'h0, d)
    axi_write(A_BAD, 32'h5, r); `CHECK("bad write resp", FUART_RESP_SLVERR, r)
    end_test("unmapped");
    axi_write(A_DIV, 32'h1, r); `CHECK("divisor resp", FUART_RESP_OKAY, r)
    i_fuart_serial_peer.send_byte(8'h77, 1'b1);
    axi_read(A_STAT, d, r); `CHECK("rx while off", 32'h0, d)
    end_test("pins disabled");
    axi_write(A_TRIG, 32'h2, r);
    axi_read(A_TRIG, d, r); `CHECK("trigger rb", 32'h2, d)
    `CHECK("pins on", 1'b1, tx_oe)
    axi_write(A_DATA, 32'ha5, r);
    axi_write(A_DATA, 32'h3c, r);
    axi_read(A_STAT, d, r); `CHECK("tx full", 32'h2, d)
    poll(FUART_ST_TX_FULL, 1'b0);
    for (int n = 0; n < 3000 && i_fuart_serial_peer.got.size() < 2; n++) @(posedge clk);
    `CHECK("tx count", 2, i_fuart_serial_peer.got.size())
    `CHECK("tx byte 0", 8'ha5, i_fuart_serial_peer.got[0])
    `CHECK("tx byte 1", 8'h3c, i_fuart_serial_peer.got[1])
    `CHECK("tx stop bits", 0, i_fuart_serial_peer.frame_err)
    axi_read(A_IST, d, r); `CHECK("int tx space", 32'h2, d)
    end_test("transmit");
    i_fuart_serial_peer.send_byte(8'h5a, 1'b1);
    poll(FUART_ST_RX_WAIT, 1'b1);
    axi_read(A_IST, d, r); `CHECK("int rx avail", 32'h1, d)
    axi_read(A_DATA, d, r); `CHECK("rx byte", 32'h5a, d)
    axi_read(A_STAT, d, r); `CHECK("ready cleared", 32'h0, d)
    end_test("receive");
    i_fuart_serial_peer.send_byte(8'h11, 1'b1);
    i_fuart_serial_peer.send_byte(8'h22, 1'b1);
    poll(FUART_ST_RX_WAIT, 1'b1);
    axi_read(A_DATA, d, r); `CHECK("newer wins", 32'h22, d)
    axi_read(A_IST, d, r); `CHECK("int overrun", 32'h5, d)
    end_test("overrun");
    axi_write(A_DIV, 32'h2, r);
    i_fuart_serial_peer.bit_clks = 48;
    axi_write(A_IMSK, 32'h1, r);
    `CHECK("irq masked idle", 1'b0, irq)
    i_fuart_serial_peer.send_byte(8'h66, 1'b1);
    for (int n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clk);
    `CHECK("irq raised", 1'b1, irq)
    axi_read(A_IST, d, r); `CHECK("int rx only", 32'h1, d)
    repeat (2) @(posedge clk);
    `CHECK("irq cleared", 1'b0, irq)
    axi_read(A_DATA, d, r); `CHECK("rx slow rate", 32'h66, d)
    end_test("interrupt");
    i_fuart_serial_peer.send_byte(8'h99, 1'b0);
    repeat (100) @(posedge clk);
    axi_read(A_STAT, d, r); `CHECK("framing drop", 32'h0, d)
    end_test("framing");
    summarize();
  end
endmodule

// file: verilog/fuart_pkg.sv
package fuart_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] FUART_IDX_DATA    = 10'h0c0;
  localparam logic [9:0] FUART_IDX_STATUS  = 10'h0c1;
  localparam logic [9:0] FUART_IDX_DIVISOR = 10'h0c1;
  localparam logic [9:0] FUART_IDX_TRIGGER = 10'h0c2;
  localparam logic [9:0] FUART_IDX_INT_ST  = 10'h0c3;
  localparam logic [9:0] FUART_IDX_INT_MSK = 10'h0c4;

  // Status field positions
  localparam int FUART_ST_RX_WAIT = 0;
  localparam int FUART_ST_TX_FULL = 1;

  // Reset values and the trigger enable value
  localparam logic [7:0] FUART_RST_DIVISOR = 8'h00;
  localparam logic [7:0] FUART_RST_TRIGGER = 8'h00;
  localparam logic [2:0] FUART_RST_INT_MSK = 3'h0;
  localparam logic [7:0] FUART_TRIG_ENABLE = 8'h02;

  // Frame timing
  localparam int         FUART_OVERSAMPLE = 16;
  localparam logic [3:0] FUART_TICK_LAST  = 4'hf;
  localparam logic [3:0] FUART_TICK_MID   = 4'h7;
  localparam logic [2:0] FUART_BIT_LAST   = 3'h7;

  // AXI responses
  localparam logic [1:0] FUART_RESP_OKAY   = 2'h0;
  localparam logic [1:0] FUART_RESP_SLVERR = 2'h2;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} fuart_tx_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} fuart_rx_e;

  // Interrupt events, also the layout of status and mask
  typedef struct packed {
    logic rx_overrun;
    logic tx_space;
    logic rx_avail;
  } fuart_evt_s;
endpackage

// file: verilog/fuart_top.sv
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
// Overview of operation
// - Software loads an 8-bit divisor through the divisor register that sets the bit rate of both directions.
// - A tick comes every divisor plus one clocks and each bit lasts sixteen ticks.
// - Transmit and receive each have a one-character holding buffer beside the shift register.
// - Every character has exactly eight data bits and no parity.
// - Each frame is one start bit, eight data bits and one stop bit.
// - Writing the data register queues the value as the next character to send; a write while the holding buffer is occupied is dropped.
// - Reading the data register returns the most recently received character.
// - Status bit 0x01 is set while a received character waits to be read.
// - Status bit 0x02 is set while the transmit holding buffer is occupied.
// - The divisor shares the status address: writes load the divisor, reads return status.
// - The serial pins are routed only after software writes the value 2 to the trigger register.
// - Lines are logic level with low as space and high as mark, idle being mark.
module fuart_top
  import fuart_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input  wire logic              SYS_CLK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [31:0]       S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  output logic [1:0]             S_AXI_BRESP_O,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  output logic [31:0]            S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  input  wire logic              UART_RX_I,
  output logic                   UART_TX_O,
  output logic                   UART_TX_OE_O,
  output logic                   IRQ_O
);

  logic              aw_full_reg, w_full_reg, w_lane_reg, bvalid_reg, rvalid_reg;
  logic [9:0]        aw_idx_reg, ar_idx;
  logic [7:0]        w_data_reg;
  logic [1:0]        bresp_reg, rresp_reg;
  logic [31:0]       rdata_reg;
  logic              do_write, do_read, wr_data, wr_div, rd_data, rd_int;
  logic [7:0]        divisor_reg, trigger_reg, div_cnt_reg;
  logic              pins_en, tick;
  logic [7:0]        tx_hold_reg, tx_shift_reg, rx_shift_reg, rx_hold_reg;
  logic              tx_full_reg, tx_line_reg, tx_take, rx_meta_reg, rx_sync_reg, rx_line, rx_done_reg, rx_ready_reg;
  logic [3:0]        tx_sub_reg, rx_sub_reg;
  logic [2:0]        tx_bit_reg, rx_bit_reg;
  fuart_tx_e         tx_state_reg;
  fuart_rx_e         rx_state_reg;
  fuart_evt_s        int_st_reg, int_msk_reg, evt;

  // AXI handshakes, one write and one read at a time
  assign S_AXI_AWREADY_O = !aw_full_reg && !bvalid_reg;
  assign S_AXI_WREADY_O  = !w_full_reg && !bvalid_reg;
  assign S_AXI_ARREADY_O = !rvalid_reg;
  assign S_AXI_BVALID_O  = bvalid_reg;
  assign S_AXI_BRESP_O   = bresp_reg;
  assign S_AXI_RVALID_O  = rvalid_reg;
  assign S_AXI_RDATA_O   = rdata_reg;
  assign S_AXI_RRESP_O   = rresp_reg;
  assign do_write = aw_full_reg && w_full_reg;
  assign do_read  = S_AXI_ARVALID_I && !rvalid_reg;
  assign ar_idx   = S_AXI_ARADDR_I[11:2];

  // Register access decode; byte lane 0 carries the data
  assign wr_data = do_write && w_lane_reg && (aw_idx_reg == FUART_IDX_DATA);
  assign wr_div  = do_write && w_lane_reg && (aw_idx_reg == FUART_IDX_DIVISOR);
  assign rd_data = do_read && (ar_idx == FUART_IDX_DATA);
  assign rd_int  = do_read && (ar_idx == FUART_IDX_INT_ST);

  // Write address and data capture, either order
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      aw_full_reg <= 1'b0;
      aw_idx_reg  <= 10'h000;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 8'h00;
      w_lane_reg  <= 1'b0;
    end
    else
    begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
      begin
        aw_full_reg <= 1'b1;
        aw_idx_reg  <= S_AXI_AWADDR_I[11:2];
      end
      else if (do_write)
        aw_full_reg <= 1'b0;
      if (S_AXI_WVALID_I && S_AXI_WREADY_O)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA_I[7:0];
        w_lane_reg <= S_AXI_WSTRB_I[0];
      end
      else if (do_write)
        w_full_reg <= 1'b0;
    end
  end

  // Write response, error on unmapped index
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= FUART_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      case (aw_idx_reg)
        FUART_IDX_DATA, FUART_IDX_DIVISOR, FUART_IDX_TRIGGER, FUART_IDX_INT_MSK:
          bresp_reg <= FUART_RESP_OKAY;
        default:
          bresp_reg <= FUART_RESP_SLVERR;
      endcase
    end
    else if (S_AXI_BREADY_I)
      bvalid_reg <= 1'b0;
  end

  // Read data path, registered one cycle after address
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      rvalid_reg    <= 1'b0;
      rdata_reg     <= 32'h0000_0000;
      rresp_reg     <= FUART_RESP_OKAY;
    end
    else if (do_read)
    begin
      rvalid_reg    <= 1'b1;
      rresp_reg     <= FUART_RESP_OKAY;
      rdata_reg     <= 32'h0000_0000;
      case (ar_idx)
        FUART_IDX_DATA:
          rdata_reg[7:0] <= rx_hold_reg;
        FUART_IDX_STATUS:
        begin
          rdata_reg[FUART_ST_RX_WAIT] <= rx_ready_reg;
          rdata_reg[FUART_ST_TX_FULL] <= tx_full_reg;
        end
        FUART_IDX_TRIGGER:
          rdata_reg[7:0] <= trigger_reg;
        FUART_IDX_INT_ST:
          rdata_reg[2:0] <= int_st_reg;
        FUART_IDX_INT_MSK:
          rdata_reg[2:0] <= int_msk_reg;
        default:
          rresp_reg <= FUART_RESP_SLVERR;
      endcase
    end
    else if (S_AXI_RREADY_I)
      rvalid_reg <= 1'b0;
  end

  // Control registers: divisor, pin trigger, interrupt mask
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      divisor_reg <= FUART_RST_DIVISOR;
      trigger_reg <= FUART_RST_TRIGGER;
      int_msk_reg <= FUART_RST_INT_MSK;
    end
    else
    begin
      if (wr_div)
        divisor_reg <= w_data_reg;
      if (do_write && w_lane_reg && (aw_idx_reg == FUART_IDX_TRIGGER))
        trigger_reg <= w_data_reg;
      if (do_write && w_lane_reg && (aw_idx_reg == FUART_IDX_INT_MSK))
        int_msk_reg <= w_data_reg[2:0];
    end
  end
  assign pins_en = (trigger_reg == FUART_TRIG_ENABLE);

  // Oversampling tick every divisor plus one clocks
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      div_cnt_reg <= 8'h00;
    else if (div_cnt_reg >= divisor_reg)
      div_cnt_reg <= 8'h00;
    else
      div_cnt_reg <= div_cnt_reg + 8'h01;
  end
  assign tick = (div_cnt_reg >= divisor_reg);

  // Transmit holding buffer
  assign tx_take = (tx_state_reg == TX_IDLE) && tx_full_reg && pins_en;
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      tx_hold_reg <= 8'h00;
      tx_full_reg <= 1'b0;
    end
    else if (tx_take)
      tx_full_reg <= 1'b0;
    else if (wr_data && !tx_full_reg)
    begin
      tx_hold_reg <= w_data_reg;
      tx_full_reg <= 1'b1;
    end
  end

  // Transmit shifter, start, eight data bits LSB first, stop
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      tx_state_reg <= TX_IDLE;
      tx_sub_reg   <= 4'h0;
      tx_bit_reg   <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_line_reg  <= 1'b1;
    end
    else
    begin
      case (tx_state_reg)
        TX_IDLE:
        begin
          tx_line_reg <= 1'b1;
          if (tx_take)
          begin
            tx_shift_reg <= tx_hold_reg;
            tx_sub_reg   <= 4'h0;
            tx_line_reg  <= 1'b0;
            tx_state_reg <= TX_START;
          end
        end
        TX_START, TX_DATA, TX_STOP:
        begin
          if (tick)
          begin
            tx_sub_reg <= tx_sub_reg + 4'h1;
            if (tx_sub_reg == FUART_TICK_LAST)
            begin
              case (tx_state_reg)
                TX_START:
                begin
                  tx_state_reg <= TX_DATA;
                  tx_bit_reg   <= 3'h0;
                  tx_line_reg  <= tx_shift_reg[0];
                end
                TX_DATA:
                begin
                  if (tx_bit_reg == FUART_BIT_LAST)
                  begin
                    tx_state_reg <= TX_STOP;
                    tx_line_reg  <= 1'b1;
                  end
                  else
                  begin
                    tx_bit_reg   <= tx_bit_reg + 3'h1;
                    tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                    tx_line_reg  <= tx_shift_reg[1];
                  end
                end
                default:
                  tx_state_reg <= TX_IDLE;
              endcase
            end
          end
        end
        default:
          tx_state_reg <= TX_IDLE;
      endcase
    end
  end
  assign UART_TX_O    = pins_en ? tx_line_reg : 1'b1;
  assign UART_TX_OE_O = pins_en;

  // Receive line synchroniser
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= UART_RX_I;
      rx_sync_reg <= rx_meta_reg;
    end
  end
  assign rx_line = pins_en ? rx_sync_reg : 1'b1;

  // Receive shifter, mid-bit sampling on the sixteen-tick grid
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      rx_state_reg <= RX_IDLE;
      rx_sub_reg   <= 4'h0;
      rx_bit_reg   <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_done_reg  <= 1'b0;
    end
    else
    begin
      rx_done_reg <= 1'b0;
      if (tick)
      begin
        rx_sub_reg <= rx_sub_reg + 4'h1;
        case (rx_state_reg)
          RX_IDLE:
          begin
            rx_sub_reg <= 4'h0;
            if (!rx_line)
              rx_state_reg <= RX_START;
          end
          RX_START:
            if (rx_sub_reg == FUART_TICK_MID)
            begin
              rx_sub_reg   <= 4'h0;
              rx_bit_reg   <= 3'h0;
              rx_state_reg <= rx_line ? RX_IDLE : RX_DATA;
            end
          RX_DATA:
            if (rx_sub_reg == FUART_TICK_LAST)
            begin
              rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
              rx_bit_reg   <= rx_bit_reg + 3'h1;
              if (rx_bit_reg == FUART_BIT_LAST)
                rx_state_reg <= RX_STOP;
            end
          RX_STOP:
            if (rx_sub_reg == FUART_TICK_LAST)
            begin
              rx_done_reg  <= rx_line;
              rx_state_reg <= RX_IDLE;
            end
          default:
            rx_state_reg <= RX_IDLE;
        endcase
      end
    end
  end

  // Receive holding buffer and data-ready flag
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      rx_hold_reg  <= 8'h00;
      rx_ready_reg <= 1'b0;
    end
    else if (rx_done_reg)
    begin
      rx_hold_reg  <= rx_shift_reg;
      rx_ready_reg <= 1'b1;
    end
    else if (rd_data)
      rx_ready_reg <= 1'b0;
  end

  // Sticky interrupt status, read clears, set wins
  assign evt = '{rx_overrun: rx_done_reg && rx_ready_reg && !rd_data, tx_space: tx_take, rx_avail: rx_done_reg};
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      int_st_reg <= 3'h0;
    else if (rd_int)
      int_st_reg <= evt;
    else
      int_st_reg <= int_st_reg | evt;
  end
  assign IRQ_O = |(int_st_reg & int_msk_reg);

  // Checks; a divisor write near a tick may stretch one period, so the tick check allows it
  property p_tx_idle_mark;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I) (tx_state_reg == TX_IDLE) && !tx_take |=> UART_TX_O;
  endproperty
  a_tx_idle_mark: assert property (p_tx_idle_mark) else $error("TX not mark when idle");
  property p_start_low;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I) tx_take |=> !UART_TX_O && (tx_state_reg == TX_START);
  endproperty
  a_start_low: assert property (p_start_low) else $error("Start bit not low");
  property p_pins_gated;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I) !pins_en |-> UART_TX_O && !UART_TX_OE_O && !tx_take;
  endproperty
  a_pins_gated: assert property (p_pins_gated) else $error("Pins active before trigger");
  property p_div_load;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I) wr_div |=> divisor_reg == $past(w_data_reg);
  endproperty
  a_div_load: assert property (p_div_load) else $error("Divisor not loaded");
  property p_tick_period;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    tick && !wr_div && $stable(divisor_reg) && (divisor_reg == 8'h01)
      |=> !tick ##1 (tick || $changed(divisor_reg));
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("Tick period wrong");
  property p_tx_bit_edge;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    ($past(tx_state_reg) != TX_IDLE) && (tx_state_reg != $past(tx_state_reg))
      |-> $past(tick) && ($past(tx_sub_reg) == FUART_TICK_LAST);
  endproperty
  a_tx_bit_edge: assert property (p_tx_bit_edge) else $error("TX bit length not sixteen ticks");
  property p_tx_queue;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    wr_data && !tx_full_reg && !tx_take |=> tx_full_reg && (tx_hold_reg == $past(w_data_reg));
  endproperty
  a_tx_queue: assert property (p_tx_queue) else $error("Write not queued");
  property p_status_read;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    do_read && (ar_idx == FUART_IDX_STATUS)
      |=> (S_AXI_RDATA_O == {30'h0, $past(tx_full_reg), $past(rx_ready_reg)});
  endproperty
  a_status_read: assert property (p_status_read) else $error("Status read wrong");
  property p_rd_clear;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I) rd_data && !rx_done_reg |=> !rx_ready_reg;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("Data ready not cleared");
  property p_overwrite;
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    rx_done_reg |=> rx_ready_reg && (rx_hold_reg == $past(rx_shift_reg));
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("Held character not replaced");

endmodule
